//--- verilog/bxf_pkg.sv
// Shared constants, types and helpers of the expand, blend and fill engine
package bxf_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL0 = 8'h00;
   localparam logic [7:0] OFF_CTRL1 = 8'h04;
   localparam logic [7:0] OFF_CTRL2 = 8'h08;
   localparam logic [7:0] OFF_SIZE = 8'h0c;
   localparam logic [7:0] OFF_FG = 8'h10;
   localparam logic [7:0] OFF_BG = 8'h14;
   localparam logic [7:0] OFF_ALPHA = 8'h18;
   localparam logic [7:0] OFF_STAT = 8'h1c;
   localparam logic [7:0] OFF_HOST = 8'h20;
   localparam logic [7:0] OFF_PAL = 8'h24;
   // Field positions
   localparam int GO_BIT = 0;
   localparam int HOST16_BIT = 1;
   localparam int BUSY_BIT = 3;
   localparam int PIXMODE_BIT = 7;
   localparam int PAL_IDX_LSB = 12;
   // Depth codes and operation codes
   localparam logic [1:0] DEPTH8 = 2'h0;
   localparam logic [1:0] DEPTH16 = 2'h1;
   localparam logic [3:0] OP_EXP_HOST = 4'h0;
   localparam logic [3:0] OP_EXP_HOST_T = 4'h1;
   localparam logic [3:0] OP_EXP_MEM = 4'h2;
   localparam logic [3:0] OP_EXP_MEM_T = 4'h3;
   localparam logic [3:0] OP_BLEND_MEM = 4'h4;
   localparam logic [3:0] OP_BLEND_HOST = 4'h5;
   localparam logic [3:0] OP_FILL = 4'h6;
   // Alpha levels in 32nds
   localparam logic [5:0] ALPHA_ONE = 6'h20;
   localparam logic [5:0] ALPHA8_1 = 6'h0a;
   localparam logic [5:0] ALPHA8_2 = 6'h15;
   // Values after reset
   localparam logic [23:0] FG_RST = 24'hffffff;
   localparam logic [23:0] BG_RST = 24'h000000;
   localparam logic [5:0] ALPHA_RST = 6'h20;

   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EMIT, S_DRAIN} bxf_state_t;

   // One destination pixel: write strobe and colour
   typedef struct packed {
      logic wr;
      logic [23:0] data;
   } bxf_pix_t;

   // Source words sent per row for a window width
   function automatic logic [16:0] words_per_row(logic [15:0] w, logic [3:0] wmax,
                                                 logic [3:0] start);
      logic [17:0] bits;
      bits = {14'h0, wmax} + 18'h1;
      return 17'(({2'h0, w} + bits + bits - {14'h0, start} - 18'h2) / bits);
   endfunction

   // Pixel of the given depth widened to 8:8:8
   function automatic logic [23:0] to888(logic [23:0] d, logic [1:0] depth);
      if (depth == DEPTH8) return {d[7:5], 5'h0, d[4:2], 5'h0, d[1:0], 6'h0};
      if (depth == DEPTH16) return {d[15:11], 3'h0, d[10:5], 2'h0, d[4:0], 3'h0};
      return d;
   endfunction

   // 8:8:8 colour narrowed to the given depth
   function automatic logic [23:0] from888(logic [23:0] c, logic [1:0] depth);
      if (depth == DEPTH8) return {16'h0, c[23:21], c[15:13], c[7:6]};
      if (depth == DEPTH16) return {8'h0, c[23:19], c[15:10], c[7:3]};
      return c;
   endfunction

   // 4:4:4 colour widened to 8:8:8
   function automatic logic [23:0] c444(logic [11:0] c);
      return {c[11:8], 4'h0, c[7:4], 4'h0, c[3:0], 4'h0};
   endfunction
endpackage

//--- verilog/bxf_unpack.sv
// Picks one monochrome source bit out of a source word
`timescale 1ns/1ps
module bxf_unpack import bxf_pkg::*; (
   // Source word and position
   input wire logic [15:0] word,
   input wire logic [3:0] cnt,
   input wire logic wide,
   input wire logic lsb_first,
   // Selected bit
   output logic bit_out
);
   logic [3:0] pos;

   // The counter runs down; low-first order mirrors it inside the word
   always_comb begin
      pos = lsb_first ? ((wide ? 4'hf : 4'h7) - cnt) : cnt;
      bit_out = word[pos];
   end
endmodule // bxf_unpack

//--- verilog/bxf_blend.sv
// Alpha blend of one first-source pixel against one second-source pixel
`timescale 1ns/1ps
module bxf_blend import bxf_pkg::*; (
   // Mode
   input wire logic [1:0] depth,
   input wire logic pix_mode,
   input wire logic [5:0] alpha_pic,
   // Pixels
   input wire logic [23:0] s0,
   input wire logic [23:0] s1,
   input wire logic [11:0] pal,
   // Result at the destination depth
   output logic [23:0] mix,
   output logic [5:0] alpha
);
   logic [23:0] a888, b888, m888;

   // One channel: (a*x + (32-a)*y) / 32
   function automatic logic [7:0] mix_ch(logic [7:0] x, logic [7:0] y, logic [5:0] a);
      logic [13:0] s;
      // Operands widened first so no product is cut at eight bits
      s = {8'h0, a} * {6'h0, x} + {8'h0, ALPHA_ONE - a} * {6'h0, y};
      return s[12:5];
   endfunction

   // Alpha and second colour per mode; 24 bpp always uses the register
   always_comb begin
      a888 = to888(s0, depth);
      b888 = to888(s1, depth);
      alpha = (alpha_pic > ALPHA_ONE) ? ALPHA_ONE : alpha_pic;
      if (pix_mode && depth == DEPTH16) begin
         alpha = (s1[15:12] == 4'hf) ? ALPHA_ONE : {1'b0, s1[15:12], 1'b0};
         b888 = c444(s1[11:0]);
      end else if (pix_mode && depth == DEPTH8) begin
         case (s1[7:6])
            2'h0: alpha = 6'h00;
            2'h1: alpha = ALPHA8_1;
            2'h2: alpha = ALPHA8_2;
            default: alpha = ALPHA_ONE;
         endcase
         b888 = c444(pal);
      end
      m888 = {mix_ch(a888[23:16], b888[23:16], alpha), mix_ch(a888[15:8], b888[15:8], alpha),
              mix_ch(a888[7:0], b888[7:0], alpha)};
      mix = from888(m888, depth);
   end
endmodule // bxf_blend

//--- verilog/bxf_engine.sv
// Colour expansion, alpha blend and solid fill engine with APB registers
// Function
// - Host expansion word width is host bus width
// - Start bit field picks first bit used
// - Host words unpack low bit first
// - Memory words unpack high bit first
// - One bits give foreground, zero bits background
// - Bits before start or past width dropped
// - Words per row follow the ceiling formula
// - Transparent mode leaves zero-bit pixels unwritten
// - Memory expansion width from depth field
// - Picture mode blends with one alpha register
// - Pixel mode only at 8 and 16 bpp
// - 16 bpp: alpha top nibble, colour low twelve
// - 16 bpp code n is 2n/32, fifteen is one
// - 8 bpp: alpha top two, palette colour
// - 8 bpp codes give 0, 10/32, 21/32, 1
// - Host blend takes first source from host
// - Solid fill writes foreground to whole window
// - Foreground and background colour registers
// - Busy bit shows operation in progress
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module bxf_engine import bxf_pkg::*; (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // First source from memory
   input wire logic FIRST_VALID,
   input wire logic [23:0] FIRST_DATA,
   output logic FIRST_READY,
   // Second source from memory
   input wire logic SECOND_VALID,
   input wire logic [23:0] SECOND_DATA,
   output logic SECOND_READY,
   // Destination window pixels
   output logic DEST_VALID,
   output bxf_pix_t DEST_PIX,
   input wire logic DEST_READY
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      bxf_state_t st;
      logic busy;
      logic host16;
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [15:0] w;
      logic [15:0] h;
      logic [23:0] fg;
      logic [23:0] bg;
      logic [5:0] alpha;
      logic [15:0] x;
      logic [15:0] y;
      logic [3:0] cnt;
      logic [15:0] word;
      logic [23:0] s0;
      logic [23:0] s1;
      logic s0_ok;
      logic s1_ok;
      logic src_rdy;
      logic s1_rdy;
      logic [16:0] row_words;
      logic dvalid;
      bxf_pix_t dpix;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } bxf_eng_t;

   localparam bxf_eng_t ENG_RST = '{st: S_IDLE, fg: FG_RST, bg: BG_RST, alpha: ALPHA_RST,
                                    default: '0};

   bxf_eng_t q, n;
   logic [11:0] pal_mem [0:63];
   logic [3:0] op, wmax, first_cnt;
   logic [1:0] depth;
   logic host_src, host_exp, is_exp, is_blend, is_fill, transp, wide;
   logic wr, stall, mapped, emit, ex_bit, start_ok;
   logic [31:0] rdata;
   logic [23:0] mix;
   logic [5:0] blend_alpha;

   // ---------------------------------------------------------------
   // Operation decode
   // ---------------------------------------------------------------
   always_comb begin
      op = q.ctrl1[3:0];
      depth = q.ctrl2[6:5];
      host_exp = op == OP_EXP_HOST || op == OP_EXP_HOST_T;
      host_src = host_exp || op == OP_BLEND_HOST;
      is_exp = op <= OP_EXP_MEM_T;
      is_blend = op == OP_BLEND_MEM || op == OP_BLEND_HOST;
      is_fill = op == OP_FILL;
      transp = op == OP_EXP_HOST_T || op == OP_EXP_MEM_T;
      // Host width for host words, depth field for memory words
      wide = host_exp ? q.host16 : (depth != DEPTH8);
      wmax = wide ? 4'hf : 4'h7;
      first_cnt = q.ctrl1[7:4] & wmax;
      emit = q.st == S_EMIT && (!q.dvalid || DEST_READY);
      wr = PSEL && PENABLE && PWRITE && q.pready;
      // Host data waits until the engine wants a word
      stall = PWRITE && PADDR == OFF_HOST && q.busy && host_src &&
              !(q.st == S_FETCH && !q.s0_ok);
      start_ok = PWDATA[GO_BIT] && q.st == S_IDLE && op <= OP_FILL && q.w != 16'h0 &&
                 q.h != 16'h0;
   end

   // ---------------------------------------------------------------
   // Datapath helpers
   // ---------------------------------------------------------------
   bxf_unpack u_unpack (
      .word(q.word),
      .cnt(q.cnt),
      .wide(wide),
      .lsb_first(host_exp),
      .bit_out(ex_bit)
   );

   bxf_blend u_blend (
      .depth(depth),
      .pix_mode(q.ctrl2[PIXMODE_BIT]),
      .alpha_pic(q.alpha),
      .s0(q.s0),
      .s1(q.s1),
      .pal(pal_mem[q.s1[5:0]]),
      .mix(mix),
      .alpha(blend_alpha)
   );

   // Register read mux
   always_comb begin
      mapped = 1'b1;
      case (PADDR)
         OFF_CTRL0: rdata = {30'h0, q.host16, 1'b0};
         OFF_CTRL1: rdata = {24'h0, q.ctrl1};
         OFF_CTRL2: rdata = {24'h0, q.ctrl2};
         OFF_SIZE: rdata = {q.h, q.w};
         OFF_FG: rdata = {8'h0, q.fg};
         OFF_BG: rdata = {8'h0, q.bg};
         OFF_ALPHA: rdata = {26'h0, q.alpha};
         OFF_STAT: rdata = {28'h0, q.busy, 3'h0};
         OFF_HOST, OFF_PAL: rdata = 32'h0;
         default: begin
            rdata = 32'h0;
            mapped = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      n = q;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      // Answer one cycle into the access phase unless host data must wait
      if (PSEL && PENABLE && !q.pready && !stall) begin
         n.pready = 1'b1;
         n.pslverr = !mapped;
         n.prdata = rdata;
      end
      // Writes land on the edge that sees pready; setup is frozen while busy
      if (wr) begin
         case (PADDR)
            OFF_CTRL0: begin
               if (q.st == S_IDLE) n.host16 = PWDATA[HOST16_BIT];
               if (start_ok) begin
                  n.st = is_fill ? S_EMIT : S_FETCH;
                  n.x = 16'h0;
                  n.y = 16'h0;
                  n.cnt = first_cnt;
                  n.s0_ok = 1'b0;
                  n.s1_ok = 1'b0;
                  n.row_words = 17'h0;
               end
            end
            OFF_CTRL1: if (q.st == S_IDLE) n.ctrl1 = PWDATA[7:0];
            OFF_CTRL2: if (q.st == S_IDLE) n.ctrl2 = PWDATA[7:0];
            OFF_SIZE: if (q.st == S_IDLE) {n.h, n.w} = PWDATA;
            OFF_FG: if (q.st == S_IDLE) n.fg = PWDATA[23:0];
            OFF_BG: if (q.st == S_IDLE) n.bg = PWDATA[23:0];
            OFF_ALPHA: if (q.st == S_IDLE) n.alpha = PWDATA[5:0];
            OFF_HOST: begin
               if (q.st == S_FETCH && host_src && !q.s0_ok) begin
                  n.word = PWDATA[15:0];
                  n.s0 = PWDATA[23:0];
                  n.s0_ok = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Destination slot frees when taken
      if (q.dvalid && DEST_READY) n.dvalid = 1'b0;
      // Memory source handshakes
      if (q.src_rdy && FIRST_VALID) begin
         n.word = FIRST_DATA[15:0];
         n.s0 = FIRST_DATA;
         n.s0_ok = 1'b1;
      end
      if (q.s1_rdy && SECOND_VALID) begin
         n.s1 = SECOND_DATA;
         n.s1_ok = 1'b1;
      end
      case (q.st)
         S_IDLE: ;
         S_FETCH: begin
            if (n.s0_ok && (n.s1_ok || !is_blend)) begin
               n.st = S_EMIT;
               if (is_exp) n.row_words = q.row_words + 17'h1;
            end
         end
         S_EMIT: begin
            if (emit) begin
               n.dvalid = 1'b1;
               if (is_fill) begin
                  n.dpix = '{wr: 1'b1, data: q.fg};
               end else if (is_exp) begin
                  n.dpix.data = ex_bit ? q.fg : q.bg;
                  n.dpix.wr = ex_bit || !transp;
               end else begin
                  n.dpix = '{wr: 1'b1, data: mix};
               end
               if (q.x == q.w - 16'h1) begin
                  // Row end: remaining bits of the word are dropped
                  n.x = 16'h0;
                  n.cnt = first_cnt;
                  n.row_words = 17'h0;
                  if (q.y == q.h - 16'h1) begin
                     n.st = S_DRAIN;
                  end else begin
                     n.y = q.y + 16'h1;
                     if (!is_fill) begin
                        n.st = S_FETCH;
                        n.s0_ok = 1'b0;
                        n.s1_ok = 1'b0;
                     end
                  end
               end else begin
                  n.x = q.x + 16'h1;
                  if (is_blend || (is_exp && q.cnt == 4'h0)) begin
                     n.st = S_FETCH;
                     n.s0_ok = 1'b0;
                     n.s1_ok = 1'b0;
                  end
                  if (is_exp) n.cnt = (q.cnt == 4'h0) ? wmax : q.cnt - 4'h1;
               end
            end
         end
         S_DRAIN: if (!n.dvalid) n.st = S_IDLE;
         default: n.st = S_IDLE;
      endcase
      n.busy = n.st != S_IDLE;
      n.src_rdy = n.st == S_FETCH && !n.s0_ok && !host_src;
      n.s1_rdy = n.st == S_FETCH && !n.s1_ok && is_blend;
   end

   // Single state register
   always_ff @(posedge CLOCK) begin
      if (!RST_N) q <= ENG_RST;
      else q <= n;
   end

   // Palette entries are written only while idle; no reset, as in a RAM
   always_ff @(posedge CLOCK) begin
      if (wr && PADDR == OFF_PAL && q.st == S_IDLE) pal_mem[PWDATA[17:12]] <= PWDATA[11:0];
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign PRDATA = q.prdata;
   assign PREADY = q.pready;
   assign PSLVERR = q.pslverr;
   assign FIRST_READY = q.src_rdy;
   assign SECOND_READY = q.s1_rdy;
   assign DEST_VALID = q.dvalid;
   assign DEST_PIX = q.dpix;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   sequence exp_emit;
      emit && is_exp;
   endsequence

   chk_fill_colour: assert property (emit && is_fill |=> DEST_VALID && DEST_PIX.wr &&
      DEST_PIX.data == q.fg) else $error("fill pixel not foreground");
   chk_expand_colour: assert property (exp_emit |=>
      DEST_PIX.data == ($past(ex_bit) ? q.fg : q.bg)) else $error("expanded colour wrong");
   chk_transparent_skip: assert property (exp_emit |=>
      DEST_PIX.wr == ($past(ex_bit) || !transp)) else $error("transparent write wrong");
   chk_row_words: assert property ((exp_emit and (q.x == q.w - 16'h1)) |->
      q.row_words == words_per_row(q.w, wmax, first_cnt)) else $error("words per row wrong");
   chk_row_start: assert property ((exp_emit and (q.x == 16'h0)) |->
      q.cnt == first_cnt) else $error("row not at start bit");
   chk_lsb_first: assert property ((exp_emit and (host_exp && q.cnt == wmax)) |->
      ex_bit == q.word[0]) else $error("host word not low bit first");
   chk_msb_first: assert property ((exp_emit and (!host_exp && q.cnt == wmax)) |->
      ex_bit == q.word[wmax]) else $error("memory word not high bit first");
   chk_alpha_full: assert property (emit && is_blend && blend_alpha == ALPHA_ONE
      |=> DEST_PIX.data == from888(to888($past(q.s0), depth), depth))
      else $error("full alpha not first source");
   chk_alpha16_zero: assert property (emit && is_blend && q.ctrl2[PIXMODE_BIT] &&
      depth == DEPTH16 && q.s1[15:12] == 4'h0 |=>
      DEST_PIX.data == from888(c444($past(q.s1[11:0])), DEPTH16))
      else $error("zero alpha not second source");
   chk_busy_start: assert property (wr && PADDR == OFF_CTRL0 && start_ok |=>
      q.busy ##1 q.busy) else $error("busy not raised");
endmodule // bxf_engine

//--- test/bxf_mem_model.sv
// Display memory side model: two source streams and a destination sink
`timescale 1ns/1ps
module bxf_mem_model import bxf_pkg::*; (
   // Clock, reset and stall mode
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   // Source streams
   output logic fv,
   output logic [23:0] fd,
   input wire logic fr,
   output logic sv,
   output logic [23:0] sd,
   input wire logic sr,
   // Destination sink
   input wire logic dv,
   input wire bxf_pix_t dp,
   output logic dr
);
   logic [23:0] fq[$];
   logic [23:0] sq[$];
   bxf_pix_t dq[$];
   logic [7:0] lf = 8'h5a;

   // Streams hand out exactly the loaded words, in order; valid holds until taken
   always @(posedge clk) begin
      lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      dr <= rst_n && (!slow || lf[0]);
      if (rst_n && dv && dr) dq.push_back(dp);
      if (fv && fr) void'(fq.pop_front());
      if (sv && sr) void'(sq.pop_front());
      if (!rst_n) begin
         fv <= 1'b0;
         sv <= 1'b0;
         fd <= 24'h000000;
         sd <= 24'h000000;
      end else begin
         // Released data toggles so a stale word is never mistaken for a live one
         if (!fv || fr) begin
            fv <= fq.size() > 0 && !(slow && lf[1]);
            fd <= (fq.size() > 0 && !(slow && lf[1])) ? fq[0] : ~fd;
         end
         if (!sv || sr) begin
            sv <= sq.size() > 0 && !(slow && lf[2]);
            sd <= (sq.size() > 0 && !(slow && lf[2])) ? sq[0] : ~sd;
         end
      end
   end
endmodule // bxf_mem_model

//--- test/test_blit_expand_blend_fill.sv
// Self-checking bench of the expand, blend and fill engine
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module test_blit_expand_blend_fill import bxf_pkg::*; ;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic slow = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] seed = 32'h3d9a;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, fv, fr, sv, sr, dv, dr;
   wire logic [23:0] fd, sd;
   wire bxf_pix_t dpix;
   int errors = 0;
   int total_checks = 0;

   // Clock at 200 MHz
   always #2.5 clk = ~clk;

   bxf_engine dut_u (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FIRST_VALID(fv), .FIRST_DATA(fd), .FIRST_READY(fr), .SECOND_VALID(sv),
      .SECOND_DATA(sd), .SECOND_READY(sr), .DEST_VALID(dv), .DEST_PIX(dpix), .DEST_READY(dr));
   bxf_mem_model mem_u (.clk(clk), .rst_n(rst_n), .slow(slow), .fv(fv), .fd(fd), .fr(fr),
      .sv(sv), .sd(sd), .sr(sr), .dv(dv), .dp(dpix), .dr(dr));

   // ---------------------------------
   // Expectation helpers
   // ---------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [23:0] wid(logic [23:0] d, logic [1:0] dp);
      if (dp == DEPTH8) return {d[7:5], 5'h0, d[4:2], 5'h0, d[1:0], 6'h0};
      if (dp == DEPTH16) return {d[15:11], 3'h0, d[10:5], 2'h0, d[4:0], 3'h0};
      return d;
   endfunction
   function automatic logic [23:0] nar(logic [23:0] c, logic [1:0] dp);
      if (dp == DEPTH8) return {16'h0, c[23:21], c[15:13], c[7:6]};
      if (dp == DEPTH16) return {8'h0, c[23:19], c[15:10], c[7:3]};
      return c;
   endfunction
   function automatic logic [23:0] c4(logic [11:0] c);
      return {c[11:8], 4'h0, c[7:4], 4'h0, c[3:0], 4'h0};
   endfunction
   function automatic logic [23:0] mixc(int a, logic [23:0] x, logic [23:0] y);
      logic [23:0] r;
      for (int i = 0; i < 3; i++)
         r[i*8 +: 8] = 8'((a * x[i*8 +: 8] + (32 - a) * y[i*8 +: 8]) >> 5);
      return r;
   endfunction

   // ---------------------------------
   // Bus tasks
   // ---------------------------------
   // Request held from setup until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 3000);
      if (n >= 3000) errors++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   // Poll busy until clear, bounded
   task automatic wait_idle();
      logic [31:0] q;
      logic e;
      int n;
      n = 0;
      do begin apb(1'b0, OFF_STAT, 32'h0, q, e); n++; end while (q[BUSY_BIT] !== 1'b0 && n < 500);
      `CHK("busy_end", 1'b0, q[BUSY_BIT])
   endtask
   task automatic check(input bxf_pix_t eq[$], input string nm);
      `CHK(nm, eq.size(), mem_u.dq.size())
      foreach (eq[i]) if (i < mem_u.dq.size()) begin
         if (eq[i].wr) `CHK(nm, eq[i], mem_u.dq[i])
         else `CHK(nm, 1'b0, mem_u.dq[i].wr)
      end
      $display("test %s done", nm);
   endtask
   task automatic cfg(input logic [3:0] op, input int st, input logic [7:0] c2, input int w, h,
                      input logic [23:0] fg, bg, input logic h16);
      mem_u.dq.delete();
      slow <= 1'(rnd());
      wr(OFF_CTRL0, {30'h0, h16, 1'b0});
      wr(OFF_CTRL1, {24'h0, 4'(st), op});
      wr(OFF_CTRL2, {24'h0, c2});
      wr(OFF_SIZE, {16'(h), 16'(w)});
      wr(OFF_FG, {8'h0, fg});
      wr(OFF_BG, {8'h0, bg});
   endtask

   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic fill_op();
      logic [23:0] fg;
      bxf_pix_t eq[$];
      logic [31:0] q;
      logic e;
      int w;
      w = rnd() % 30 + 20;
      fg = 24'(rnd());
      cfg(OP_FILL, 0, 8'h40, w, 2, fg, ~fg, 1'b0);
      repeat (w * 2) eq.push_back({1'b1, fg});
      wr(OFF_CTRL0, 32'h1);
      apb(1'b0, OFF_STAT, 32'h0, q, e);
      `CHK("busy_run", 1'b1, q[BUSY_BIT])
      wait_idle();
      check(eq, "fill");
   endtask
   // Corner k=0: start 0 and width of one word; k=1: highest start bit
   task automatic exp_op(input logic [3:0] op, input logic h16, input logic [1:0] dp, input int k);
      int bits, st, w, h, nw, n, pos, idx;
      logic [15:0] v;
      logic [15:0] wd[$];
      bxf_pix_t eq[$];
      logic [23:0] fg, bg;
      logic host;
      host = (op == OP_EXP_HOST || op == OP_EXP_HOST_T);
      bits = host ? (h16 ? 16 : 8) : (dp == DEPTH8 ? 8 : 16);
      st = k == 0 ? 0 : k == 1 ? bits - 1 : rnd() % bits;
      w = k == 0 ? bits : rnd() % 40 + 1;
      h = rnd() % 3 + 1;
      nw = (w + 2 * bits - st - 2) / bits;
      fg = 24'(rnd());
      bg = fg ^ 24'h5a5a5a;
      for (int r = 0; r < h; r++) begin
         pos = 0;
         for (int j = 0; j < nw; j++) begin
            v = 16'(rnd()) & (bits == 8 ? 16'h00ff : 16'hffff);
            wd.push_back(v);
            n = j ? bits : st + 1;
            for (int b = 0; b < n; b++) begin
               idx = host ? bits - n + b : n - 1 - b;
               if (pos < w) eq.push_back({v[idx] | !op[0], v[idx] ? fg : bg});
               pos++;
            end
         end
      end
      // Host runs get the opposite depth field, which must not matter
      cfg(op, st, {1'b0, host ? {1'b0, !h16} : dp, 5'h0}, w, h, fg, bg, h16);
      if (!host) foreach (wd[i]) mem_u.fq.push_back({8'h0, wd[i]});
      wr(OFF_CTRL0, {30'h0, h16, 1'b1});
      if (host) foreach (wd[i]) wr(OFF_HOST, {16'h0, wd[i]});
      wait_idle();
      check(eq, "expand");
   endtask
   task automatic blend_op(input logic [3:0] op, input logic [1:0] dp, input logic pm);
      int w, h, a, ap;
      int t8[4];
      logic [23:0] s0, s1, c1, m;
      logic [23:0] pal[4];
      logic [23:0] q0[$];
      bxf_pix_t eq[$];
      t8 = '{0, 10, 21, 32};
      w = rnd() % 5 + 1;
      h = rnd() % 2 + 1;
      // Levels above one are drawn too; they must clamp to one
      ap = rnd() % 36;
      m = dp == DEPTH8 ? 24'hff : dp == DEPTH16 ? 24'hffff : 24'hffffff;
      foreach (pal[i]) begin
         pal[i] = 24'(rnd() & 32'hfff);
         wr(OFF_PAL, {14'h0, 6'(i), pal[i][11:0]});
      end
      cfg(op, 0, {pm, dp, 5'h0}, w, h, 24'hffffff, 24'h0, 1'b0);
      wr(OFF_ALPHA, 32'(ap));
      repeat (w * h) begin
         s0 = 24'(rnd()) & m;
         s1 = 24'(rnd()) & m;
         if (pm && dp == DEPTH8) s1[5:2] = 4'h0;
         // First pixel of a 16 bpp pixel-mode run at zero alpha
         if (pm && eq.size() == 0) s1[15:12] = 4'h0;
         c1 = wid(s1, dp);
         a = ap > 32 ? 32 : ap;
         if (pm && dp == DEPTH16) begin
            a = s1[15:12] == 4'hf ? 32 : 2 * s1[15:12];
            c1 = c4(s1[11:0]);
         end
         if (pm && dp == DEPTH8) begin
            a = t8[s1[7:6]];
            c1 = c4(pal[s1[1:0]][11:0]);
         end
         eq.push_back({1'b1, nar(mixc(a, wid(s0, dp), c1), dp)});
         q0.push_back(s0);
         mem_u.sq.push_back(s1);
      end
      if (op == OP_BLEND_MEM) foreach (q0[i]) mem_u.fq.push_back(q0[i]);
      wr(OFF_CTRL0, 32'h1);
      if (op == OP_BLEND_HOST) foreach (q0[i]) wr(OFF_HOST, {8'h0, q0[i]});
      wait_idle();
      check(eq, "blend");
   endtask
   task automatic reg_test();
      logic [7:0] ra[6];
      logic [31:0] rv[6];
      logic [31:0] q;
      logic e;
      ra = '{OFF_CTRL0, OFF_CTRL1, OFF_SIZE, OFF_FG, OFF_BG, OFF_ALPHA};
      rv = '{32'h0, 32'h0, 32'h0, 32'hffffff, 32'h0, 32'h20};
      wr(OFF_STAT, 32'hff);
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0, q, e);
         `CHK("reset_val", rv[i], q)
      end
      apb(1'b0, OFF_STAT, 32'h0, q, e);
      `CHK("status", 32'h0, q)
      apb(1'b0, 8'h30, 32'h0, q, e);
      `CHK("unmapped", 33'h100000000, {e, q})
      $display("test registers done");
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      reg_test();
      fill_op();
      for (int op = 0; op < 4; op++) for (int k = 0; k < 3; k++) exp_op(4'(op), k[0], 2'(k), k);
      for (int op = 4; op < 6; op++) for (int d = 0; d < 3; d++) for (int p = 0; p < 2; p++)
         blend_op(4'(op), 2'(d), p[0]);
      conclude();
   end
   // Watchdog: far beyond the few thousand cycles the run needs
   initial begin
      #300000;
      errors++;
      conclude();
   end
endmodule // test_blit_expand_blend_fill
